/* core/ldp_curve.sv */
// maps a 7-bit duty level to on-time steps within one pwm period
`timescale 1ns/10ps
module ldp_curve (
    input  wire logic [ldp_pkg::LVL_W-1:0] level_i,
    input  wire logic                      linear_i,
    input  wire logic [ldp_pkg::PER_W-1:0] period_i,
    output logic      [ldp_pkg::PER_W-1:0] on_steps_o
);
    typedef logic [127:0][ldp_pkg::FRAC_W-1:0] ldp_tab_t;

    // table built at elaboration: frac(i) = 0.9471^(127-i), q16
    function automatic ldp_tab_t ldp_log_tab();
        ldp_tab_t    t;
        logic [47:0] v;
        v = ldp_pkg::ONE_Q16;
        for (int i = 127; i >= 0; i--) begin
            t[i] = v[ldp_pkg::FRAC_W-1:0];
            v = (v * ldp_pkg::LOG_RATIO_Q16 + ldp_pkg::HALF_Q16)
                >> ldp_pkg::FRAC_SH;
        end
        return t;
    endfunction

    function automatic ldp_tab_t ldp_lin_tab();
        ldp_tab_t    t;
        logic [47:0] v;
        for (int i = 0; i < 128; i++) begin
            v = (48'(i) * ldp_pkg::ONE_Q16 + 48'(63)) / 48'(127);
            t[i] = v[ldp_pkg::FRAC_W-1:0];
        end
        return t;
    endfunction

    localparam ldp_tab_t LOG_TAB = ldp_log_tab();
    localparam ldp_tab_t LIN_TAB = ldp_lin_tab();

    logic [ldp_pkg::FRAC_W-1:0] frac;
    logic [31:0]                prod;

    always_comb begin
        frac = linear_i ? LIN_TAB[level_i] : LOG_TAB[level_i]; // R14 R6
        prod = (32'(period_i) * 32'(frac) + 32'(ldp_pkg::HALF_Q16))
               >> ldp_pkg::FRAC_SH;
        // the log curve never reaches zero on its own, so 0 is forced off
        if (level_i == ldp_pkg::LVL_OFF) begin
            on_steps_o = '0; // R7 R8
        end else begin
            on_steps_o = prod[ldp_pkg::PER_W-1:0]; // R6
        end
    end
endmodule

/* core/ldp_dimmer.sv */
// twelve-channel led dimming core with readback and open-load flags
`timescale 1ns/10ps
module ldp_dimmer #(
    parameter int STEP_CYC       = ldp_pkg::STEP_CYC,
    parameter int PER_FAST_STEPS = ldp_pkg::PER_FAST_STEPS
) (
    input  wire logic                          ref_clk_i,
    input  wire logic                          srst_i,
    input  wire ldp_pkg::ldp_req_t             req_i,
    input  wire ldp_pkg::ldp_host_cfg_t        host_cfg_i,
    input  wire logic [ldp_pkg::NUM_CH-1:0]    standalone_set_a_i,
    input  wire logic [ldp_pkg::NUM_CH-1:0]    standalone_set_b_i,
    input  wire logic                          standalone_sel_b_i,
    input  wire logic [ldp_pkg::NUM_CH-1:0]    open_load_i,
    output logic      [15:0]                   rdata_o,
    output logic                               rvalid_o,
    output logic      [ldp_pkg::NUM_CH-1:0]    driver_output_o,
    output logic      [ldp_pkg::NUM_CH-1:0]    fault_o
);
    localparam int NCH = ldp_pkg::NUM_CH;
    localparam logic [ldp_pkg::TICK_W-1:0] STEP_LAST =
        ldp_pkg::TICK_W'(STEP_CYC - 1);
    localparam logic [ldp_pkg::OLC_W-1:0] OL_LIMIT =
        ldp_pkg::OLC_W'(ldp_pkg::OPEN_LOAD_CYC);
    localparam logic [3:0] NCH_4 = 4'(NCH);

    ldp_pkg::ldp_state_t st_q;
    ldp_pkg::ldp_state_t st_d;

    logic                               step;
    logic                               wrap;
    logic [ldp_pkg::PER_W-1:0]          period;
    logic [NCH-1:0][ldp_pkg::PER_W-1:0] on_calc;
    logic [NCH-1:0]                     dim_act;
    logic [NCH-1:0]                     static_on;
    logic [NCH-1:0]                     set_vec;
    logic [NCH-1:0]                     low_bits;
    logic                               rd_fault;
    logic                               wr_ok;

    // slower settings are the fast period doubled per step
    function automatic logic [ldp_pkg::PER_W-1:0] period_steps(
        input logic [1:0] fsel
    );
        logic [ldp_pkg::PER_W-1:0] base;
        base = ldp_pkg::PER_W'(PER_FAST_STEPS);
        return base << (ldp_pkg::FSEL_MAX - fsel);
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_curve
            ldp_curve u_curve (
                .level_i    (st_q.duty[g]),
                .linear_i   (st_q.lin),
                .period_i   (period),
                .on_steps_o (on_calc[g])
            );
        end
    endgenerate

    always_comb begin
        period = period_steps(st_q.fsel); // R15
        // global enable gates the mask without touching it
        dim_act = st_q.dim_en & {NCH{host_cfg_i.dimming_global_on}}; // R12 R16
        if (host_cfg_i.host_mode_flag) begin
            static_on = host_cfg_i.host_channel_on; // R13 R17
        end else begin
            static_on = standalone_sel_b_i ? standalone_set_b_i
                                           : standalone_set_a_i;
        end
        // a dimmed channel reads as on in host mode
        if (host_cfg_i.host_mode_flag) begin
            low_bits = host_cfg_i.host_channel_on | dim_act; // R1 R2
        end else begin
            low_bits = static_on; // R1
        end
        for (int i = 0; i < NCH; i++) begin
            set_vec[i] = st_q.ol_sync[i] && (st_q.ol_cnt[i] == OL_LIMIT); // R3
        end
        step     = (st_q.tick_cnt == STEP_LAST); // R6
        wrap     = step && (st_q.per_cnt >= period - 1'b1); // R18
        rd_fault = req_i.rd && (req_i.sel == ldp_pkg::LDP_REG_FAULT);
        wr_ok    = req_i.wr && !req_i.rd;
    end

    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;

        // 400 ns step enable and shared period counter
        st_d.tick_cnt = step ? '0 : st_q.tick_cnt + 1'b1; // R6
        if (wrap) begin
            st_d.per_cnt = '0; // R18
            // levels move to the outputs only at a period edge, so a
            // whole-set message lands on all channels at once
            st_d.on_tk = on_calc; // R11
        end else if (step) begin
            st_d.per_cnt = st_q.per_cnt + 1'b1;
        end

        for (int i = 0; i < NCH; i++) begin
            if (dim_act[i]) begin
                st_d.out[i] = (st_q.per_cnt < st_q.on_tk[i]); // R18 R7 R8
            end else begin
                st_d.out[i] = static_on[i]; // R13
            end
        end

        // open-load filter: synchronise, then count persistence
        st_d.ol_meta = open_load_i;
        st_d.ol_sync = st_q.ol_meta;
        for (int i = 0; i < NCH; i++) begin
            if (!st_q.ol_sync[i]) begin
                st_d.ol_cnt[i] = '0;
            end else if (st_q.ol_cnt[i] != OL_LIMIT) begin
                st_d.ol_cnt[i] = st_q.ol_cnt[i] + 1'b1; // R3
            end
        end
        // a new fault in the read cycle survives the clear
        st_d.fault = (rd_fault ? '0 : st_q.fault) | set_vec; // R3 R4

        if (req_i.rd) begin
            st_d.rvalid = 1'b1;
            unique case (req_i.sel)
                ldp_pkg::LDP_REG_CH_STATE: begin
                    st_d.rdata = {host_cfg_i.host_mode_flag,
                                  host_cfg_i.host_auto_recovery,
                                  host_cfg_i.host_detect_only,
                                  host_cfg_i.dimming_global_on,
                                  low_bits}; // R1
                end
                ldp_pkg::LDP_REG_FAULT: begin
                    st_d.rdata = {ldp_pkg::RD_PAD, st_q.fault}; // R4
                end
                default: begin
                    st_d.rdata = ldp_pkg::RD_NONE;
                end
            endcase
        end

        if (wr_ok) begin
            unique case (req_i.sel)
                ldp_pkg::LDP_REG_COMMON: begin
                    for (int i = 0; i < NCH; i++) begin
                        st_d.duty[i] = req_i.wdata[ldp_pkg::LVL_W-1:0]; // R5 R10
                    end
                end
                ldp_pkg::LDP_REG_CHAN: begin
                    // channel numbers past the last one are ignored
                    if (req_i.ch < NCH_4) begin
                        st_d.duty[req_i.ch] =
                            req_i.wdata[ldp_pkg::LVL_W-1:0]; // R8
                    end
                end
                ldp_pkg::LDP_REG_ALL: begin
                    st_d.duty = req_i.all_duty; // R11
                end
                ldp_pkg::LDP_REG_DIM_EN: begin
                    st_d.dim_en = req_i.wdata[NCH-1:0]; // R12
                end
                ldp_pkg::LDP_REG_CONF: begin
                    st_d.lin  = req_i.wdata[ldp_pkg::CONF_LIN_BIT]; // R14
                    st_d.fsel = req_i.wdata[1:0]; // R15
                end
                default: begin
                    st_d.lin = st_q.lin;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o         = st_q.rdata;
    assign rvalid_o        = st_q.rvalid;
    assign driver_output_o = st_q.out;
    assign fault_o         = st_q.fault;

    // checks on the logic above

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    logic [NCH-1:0] fault_new;
    assign fault_new = st_d.fault & ~st_q.fault;

    sequence s_fault_read;
        req_i.rd && (req_i.sel == ldp_pkg::LDP_REG_FAULT);
    endsequence

    sequence s_common_write;
        wr_ok && (req_i.sel == ldp_pkg::LDP_REG_COMMON);
    endsequence

    a_readback_top_bits: assert property ( // R1
        (req_i.rd && req_i.sel == ldp_pkg::LDP_REG_CH_STATE)
        |=> rvalid_o && rdata_o[15:12] == $past(host_cfg_i[15:12]))
        else $error("readback mode bits wrong");

    a_pwm_channel_reads: assert property ( // R2
        (req_i.rd && req_i.sel == ldp_pkg::LDP_REG_CH_STATE
         && host_cfg_i.host_mode_flag && dim_act[0])
        |=> rdata_o[0])
        else $error("dimmed channel not shown as on");

    a_fault_needs_persist: assert property ( // R3
        (fault_new != '0)
        |-> ((fault_new & ~st_q.ol_sync) == '0)
            && (fault_new[0] == 1'b0 || st_q.ol_cnt[0] == OL_LIMIT))
        else $error("fault set without persistent open load");

    a_fault_read_clear: assert property ( // R4
        s_fault_read ##0 (set_vec == '0)
        |=> (st_q.fault == '0) && rdata_o[15:12] == 4'h0
            && rdata_o[11:0] == $past(st_q.fault))
        else $error("fault read did not return then clear");

    a_common_to_all: assert property ( // R5
        s_common_write
        |=> (st_q.duty == {NCH{$past(req_i.wdata[6:0])}}))
        else $error("common level not copied to all channels");

    a_full_on_level: assert property ( // R7
        (dim_act[0] && st_q.duty[0] == ldp_pkg::LVL_FULL && wrap)
        ##1 (dim_act[0] && !wrap) [*2]
        |=> driver_output_o[0])
        else $error("full level did not hold output on");

    a_zero_off_level: assert property ( // R8
        (dim_act[0] && st_q.on_tk[0] == '0) |=> !driver_output_o[0])
        else $error("zero level did not hold output off");

    a_static_follow: assert property ( // R13
        (!dim_act[1] && host_cfg_i.host_mode_flag)
        |=> driver_output_o[1] == $past(host_cfg_i.host_channel_on[1]))
        else $error("undimmed channel not following on/off bit");

    a_step_spacing: assert property ( // R6
        step |=> (st_q.tick_cnt == '0) && !step)
        else $error("pwm step enable too close");

    a_mask_kept: assert property ( // R16
        $fell(host_cfg_i.dimming_global_on) && !$past(wr_ok)
        |-> st_q.dim_en == $past(st_q.dim_en) && dim_act == '0)
        else $error("global enable off lost the mask");

    a_period_wrap: assert property ( // R15
        wrap |=> st_q.per_cnt == '0 ##1 st_q.per_cnt == '0)
        else $error("period counter did not restart");

endmodule

/* core/ldp_pkg.sv */
// constants, carriers and state layout of the led dimming block
//
// Functional notes
// [R1] readback: mode bits on top, channel states below
// [R2] host mode: pwm channel reads as one
// [R3] fault sets after open load over 10 us
// [R4] fault read clears all; top bits zero
// [R5] common level write dims all twelve channels
// [R6] log curve 0.9471 power, 400 ns steps
// [R7] common level 127 full on, 0 off
// [R8] channel level 127 full on, 0 off
// [R9] host avoids zero level on faulty channel
// [R10] common write overwrites all channel levels
// [R11] host loads twelve levels in one message
// [R12] mask bit enables dimming per channel
// [R13] undimmed channel follows host on/off bit
// [R14] curve select: 0 log, 1 linear
// [R15] frequency select: 150/300/600/1200 Hz
// [R16] global enable off stops pwm, keeps mask
// [R17] host on/off bit: 0 off, 1 on
// [R18] shared period counter compared to duty
package ldp_pkg;

    localparam int NUM_CH          = 12;
    localparam int LVL_W           = 7;
    localparam int PER_W           = 15;
    localparam int TICK_W          = 6;
    localparam int OLC_W           = 10;
    localparam int FRAC_W          = 17;
    localparam int FRAC_SH         = 16;

    localparam int CLK_PERIOD_NS   = 10;
    localparam int PWM_STEP_NS     = 400;
    localparam int STEP_CYC        = (PWM_STEP_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    // fastest period, 1200 Hz; slower settings double it
    localparam int PER_FAST_NS     = 833333;
    localparam int PER_FAST_STEPS  = PER_FAST_NS / PWM_STEP_NS;
    localparam int OPEN_LOAD_NS    = 10000;
    localparam int OPEN_LOAD_CYC   = OPEN_LOAD_NS / CLK_PERIOD_NS;

    localparam logic [6:0] LVL_FULL = 7'h7F;
    localparam logic [6:0] LVL_OFF  = 7'h00;
    localparam logic [1:0] FSEL_MAX = 2'h3;

    // log curve ratio 0.9471 in q16, and one in q16
    localparam logic [47:0] LOG_RATIO_Q16 = 48'h0000_0000_F275;
    localparam logic [47:0] ONE_Q16       = 48'h0000_0001_0000;
    localparam logic [47:0] HALF_Q16      = 48'h0000_0000_8000;

    // register field positions
    localparam int CS_FLAG_BIT   = 15;
    localparam int CS_STANDALONE_AUTO_RECOVERY_BIT  = 14;
    localparam int CS_DONLY_BIT  = 13;
    localparam int CS_GON_BIT    = 12;
    localparam int CONF_LIN_BIT  = 2;
    localparam logic [15:0] RD_NONE = 16'h0000;
    localparam logic [3:0]  RD_PAD  = 4'h0;

    typedef enum logic [2:0] {
        LDP_REG_CH_STATE = 3'h0,
        LDP_REG_FAULT    = 3'h1,
        LDP_REG_COMMON   = 3'h2,
        LDP_REG_CHAN     = 3'h3,
        LDP_REG_DIM_EN   = 3'h4,
        LDP_REG_CONF     = 3'h5,
        LDP_REG_ALL      = 3'h6
    } ldp_reg_t;

    typedef struct packed {
        logic                            wr;
        logic                            rd;
        ldp_reg_t                        sel;
        logic [3:0]                      ch;
        logic [15:0]                     wdata;
        logic [NUM_CH-1:0][LVL_W-1:0]    all_duty;
    } ldp_req_t;

    typedef struct packed {
        logic              host_mode_flag;
        logic              host_auto_recovery;
        logic              host_detect_only;
        logic              dimming_global_on;
        logic [NUM_CH-1:0] host_channel_on;
    } ldp_host_cfg_t;

    typedef struct packed {
        logic [TICK_W-1:0]               tick_cnt;
        logic [PER_W-1:0]                per_cnt;
        logic [NUM_CH-1:0][LVL_W-1:0]    duty;
        logic [NUM_CH-1:0]               dim_en;
        logic                            lin;
        logic [1:0]                      fsel;
        logic [NUM_CH-1:0][PER_W-1:0]    on_tk;
        logic [NUM_CH-1:0]               ol_meta;
        logic [NUM_CH-1:0]               ol_sync;
        logic [NUM_CH-1:0][OLC_W-1:0]    ol_cnt;
        logic [NUM_CH-1:0]               fault;
        logic [NUM_CH-1:0]               out;
        logic [15:0]                     rdata;
        logic                            rvalid;
    } ldp_state_t;

endpackage

/* testbench/ldp_dimmer_tb.sv */
// self-checking bench for the led dimming block
`timescale 1ns/10ps
module ldp_dimmer_tb;
    localparam int SC = 4;
    localparam int PF = 8;
    logic                   ref_clk_i = 1'h0;
    logic                   srst_i = 1'h1;
    ldp_pkg::ldp_host_cfg_t cfg = '0;
    ldp_pkg::ldp_req_t      req;
    logic [11:0]            sa = '0;
    logic [11:0]            sb = '0;
    logic [11:0]            ol = '0;
    logic [11:0]            mask = '0;
    logic [11:0]            dout;
    logic [11:0]            flt;
    logic [15:0]            rdata;
    logic                   selb = 1'h0;
    logic                   rvalid;
    logic [31:0]            rs = 32'h0000_B4EF;
    int                     errors = 0;
    int                     comparisons = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    ldp_dimmer #(.STEP_CYC(SC), .PER_FAST_STEPS(PF)) uut (
        .ref_clk_i          (ref_clk_i),
        .srst_i             (srst_i),
        .req_i              (req),
        .host_cfg_i         (cfg),
        .standalone_set_a_i (sa),
        .standalone_set_b_i (sb),
        .standalone_sel_b_i (selb),
        .open_load_i        (ol),
        .rdata_o            (rdata),
        .rvalid_o           (rvalid),
        .driver_output_o    (dout),
        .fault_o            (flt)
    );

    ldp_host_model host (
        .ref_clk_i  (ref_clk_i),
        .auto_rec_i (cfg.host_auto_recovery),
        .fault_i    (flt),
        .rdata_i    (rdata),
        .rvalid_i   (rvalid),
        .req_o      (req)
    );

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // reference readback word; dimmed channels read as on in host mode
    function automatic logic [15:0] cs_exp();
        logic [11:0] dim;
        dim = mask & {12{cfg.dimming_global_on}};
        if (cfg.host_mode_flag)
            return {cfg[15:12], cfg.host_channel_on | dim};
        return {cfg[15:12], selb ? sb : sa};
    endfunction

    // static outputs while every level is still zero
    // dimmed channels stay dark at level zero in either mode
    function automatic logic [11:0] st_exp();
        logic [11:0] sv;
        sv = cfg.host_mode_flag ? cfg.host_channel_on : (selb ? sb : sa);
        return sv & ~(mask & {12{cfg.dimming_global_on}});
    endfunction

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e,
                       input string m);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // on-times are only exact to one step
    task automatic near(input int g, input int e, input string m);
        comparisons++;
        if (g < e - SC || g > e + SC) begin
            errors++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, m, g, e);
        end
    endtask

    task automatic rdc(input ldp_pkg::ldp_reg_t s, input logic [15:0] e);
        logic [15:0] d;
        host.rd(s, d);
        chk(d, e, "read data");
    endtask

    task automatic outs(input logic [11:0] e, input int n);
        logic [11:0] g;
        g = e;
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
            if (dout !== e)
                g = dout;
        end
        chk({4'h0, g}, {4'h0, e}, "outputs");
    endtask

    task automatic edge0();
        logic p;
        p = 1'h1;
        for (int n = 0; n < 1200; n++) begin
            @(posedge ref_clk_i);
            #1;
            if (dout[0] === 1'h1 && p === 1'h0)
                break;
            p = dout[0];
        end
    endtask

    task automatic meas(output int on, output int per);
        logic p;
        on = 0;
        p = 1'h1;
        edge0();
        for (per = 1; per < 1200; per++) begin
            on += int'(dout[0] === 1'h1);
            @(posedge ref_clk_i);
            #1;
            if (dout[0] === 1'h1 && p === 1'h0)
                break;
            p = dout[0];
        end
    endtask

    initial begin
        #300000;
        errors++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        logic [11:0][6:0] lv;
        int on;
        int per;
        int st;
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 1'h0;
        rdc(ldp_pkg::LDP_REG_CH_STATE, 16'h0000);
        rdc(ldp_pkg::LDP_REG_FAULT, 16'h0000);
        outs(12'h000, 4);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            @(posedge ref_clk_i);
            cfg <= {i[0], r[14:0]};
            sa <= r[27:16];
            sb <= r[31:20];
            selb <= r[3];
            mask = r[23:12];
            host.wr(ldp_pkg::LDP_REG_DIM_EN, 4'h0, {4'h0, mask});
            rdc(ldp_pkg::LDP_REG_CH_STATE, cs_exp());
            outs(st_exp(), 8);
        end
        @(posedge ref_clk_i);
        cfg <= 16'h9000;
        mask = 12'h003;
        host.wr(ldp_pkg::LDP_REG_DIM_EN, 4'h0, 16'h0003);
        host.wr(ldp_pkg::LDP_REG_CONF, 4'h0, 16'h0003);
        for (int k = 0; k < 12; k++)
            lv[k] = 7'(rnd() % 126 + 1);
        lv[0] = 7'h7F;
        lv[1] = 7'h00;
        host.wr_all(lv);
        repeat (600) @(posedge ref_clk_i);
        outs(12'h001, 40);
        host.wr(ldp_pkg::LDP_REG_COMMON, 4'h0, 16'h007F);
        repeat (80) @(posedge ref_clk_i);
        outs(12'h003, 40);
        host.wr(ldp_pkg::LDP_REG_CHAN, 4'h1, 16'h0000);
        repeat (80) @(posedge ref_clk_i);
        outs(12'h001, 40);
        @(posedge ref_clk_i);
        cfg <= 16'h8002;
        repeat (4) @(posedge ref_clk_i);
        outs(12'h002, 40);
        @(posedge ref_clk_i);
        cfg <= 16'h9002;
        repeat (80) @(posedge ref_clk_i);
        outs(12'h001, 40);
        host.wr(ldp_pkg::LDP_REG_COMMON, 4'h0, 16'h0000);
        repeat (80) @(posedge ref_clk_i);
        outs(12'h000, 40);
        host.wr(ldp_pkg::LDP_REG_COMMON, 4'h0, 16'h0040);
        for (int f = 3; f >= 0; f--) begin
            host.wr(ldp_pkg::LDP_REG_CONF, 4'h0, 16'(4 + f));
            edge0();
            meas(on, per);
            st = PF << (3 - f);
            chk(16'(per), 16'(st * SC), "period");
            near(on, (64 * st / 127) * SC, "linear on time");
        end
        host.wr(ldp_pkg::LDP_REG_CONF, 4'h0, 16'h0000);
        edge0();
        meas(on, per);
        near(on, int'(64.0 * 0.9471 ** 63) * SC, "log on time");
        @(posedge ref_clk_i);
        ol <= 12'h001;
        repeat (500) @(posedge ref_clk_i);
        ol <= 12'h000;
        repeat (600) @(posedge ref_clk_i);
        chk({4'h0, flt}, 16'h0000, "short open load");
        ol <= 12'h020;
        repeat (990) @(posedge ref_clk_i);
        chk({4'h0, flt}, 16'h0000, "fault too early");
        repeat (30) @(posedge ref_clk_i);
        chk({4'h0, flt}, 16'h0020, "fault set");
        ol <= 12'h000;
        // let the open load leave the synchroniser so the read clears
        repeat (4) @(posedge ref_clk_i);
        chk({4'h0, flt}, 16'h0020, "fault held");
        rdc(ldp_pkg::LDP_REG_FAULT, 16'h0020);
        chk({4'h0, flt}, 16'h0000, "fault cleared");
        rdc(ldp_pkg::LDP_REG_FAULT, 16'h0000);
        stop_test();
    end
endmodule

/* testbench/ldp_host_model.sv */
// host-side register master model for the led dimming block
`timescale 1ns/10ps
module ldp_host_model (
    input  wire logic                       ref_clk_i,
    input  wire logic                       auto_rec_i,
    input  wire logic [ldp_pkg::NUM_CH-1:0] fault_i,
    input  wire logic [15:0]                rdata_i,
    input  wire logic                       rvalid_i,
    output ldp_pkg::ldp_req_t               req_o
);
    initial req_o = '0;

    task automatic wr(input ldp_pkg::ldp_reg_t s, input logic [3:0] c,
                      input logic [15:0] d);
        // stricter than needed: with auto recovery on, any reported fault blocks a zero level
        if (auto_rec_i && d[6:0] == 7'h00 && |fault_i &&
            (s == ldp_pkg::LDP_REG_COMMON || s == ldp_pkg::LDP_REG_CHAN))
            return;
        @(posedge ref_clk_i);
        req_o.wr <= 1'h1;
        req_o.sel <= s;
        req_o.ch <= c;
        req_o.wdata <= d;
        @(posedge ref_clk_i);
        req_o.wr <= 1'h0;
    endtask

    // all twelve levels in one message so they switch together
    task automatic wr_all(input logic [11:0][6:0] l);
        @(posedge ref_clk_i);
        req_o.wr <= 1'h1;
        req_o.sel <= ldp_pkg::LDP_REG_ALL;
        req_o.all_duty <= l;
        @(posedge ref_clk_i);
        req_o.wr <= 1'h0;
    endtask

    task automatic rd(input ldp_pkg::ldp_reg_t s, output logic [15:0] d);
        @(posedge ref_clk_i);
        req_o.rd <= 1'h1;
        req_o.sel <= s;
        @(posedge ref_clk_i);
        req_o.rd <= 1'h0;
        d = 'x;
        // the answer stands for one cycle right after the taking edge
        for (int n = 0; n < 3; n++) begin
            #1;
            if (rvalid_i === 1'h1) begin
                d = rdata_i;
                break;
            end
            @(posedge ref_clk_i);
        end
    endtask
endmodule
